// ==== verilog/pmbus_fault_status_alert.sv ====
// Fault status bank, alert mask store and open-drain alert driver.
// Assumes a serial engine that hands over whole decoded transactions.
//
// Behaviour
// [R01] Clear-faults empties every status register at once
// [R02] Clear-faults releases the alert line
// [R03] Persisting fault sets its bit and alert again
// [R04] Clear finishes within ten microseconds
// [R05] Clear-faults accepted only as send byte
// [R06] Clear-faults never restarts a latched channel
// [R07] Off-on, reset command or power cycle restarts
// [R08] Peak clear on command, reset or restore
// [R09] Masked bits still record, never raise alert
// [R10] Mask set by word write: target, mask
// [R11] Mask read by process call returns target mask
// [R12] Bad mask targets refused, flag invalid data
// [R13] Masks reset zero, manufacturer mask 0x11
// [R14] Summary byte bit layout
// [R15] Off bit set whenever output not powered
// [R16] Summary fault bits start an alert
// [R17] Summary word low byte equals summary byte
// [R18] Summary word high byte bit layout
// [R19] Voltage status layout, bits 7:1 alert
// [R20] Write one clears single voltage bit
// [R21] Current status bits 7 and 5, W1C
// [R22] Manufacturer status sets word summary bit
// [R23] Alert low while unmasked bit set
// [R24] Paged registers kept per channel
`timescale 1ns/1ns
module pmbus_fault_status_alert
  import pmbus_fault_pkg::*;
#(
  parameter int NUM_CH = 2,
  parameter logic [7:0] RESET_CMD_CODE = 8'hF0,
  parameter logic [7:0] RESTORE_CMD_CODE = 8'hF1,
  parameter int PW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Decoded command
  input wire logic i_cmd_valid,
  input wire cmd_kind_t i_cmd_kind,
  input wire logic [7:0] i_cmd_code,
  input wire logic [7:0] i_cmd_d0,
  input wire logic [7:0] i_cmd_d1,
  input wire logic [PW-1:0] i_page,
  // Read answer
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_data,
  // Detector levels, asynchronous
  input wire logic [NUM_CH-1:0][6:0] i_vout_fault,
  input wire logic [NUM_CH-1:0][1:0] i_iout_fault,
  input wire logic [NUM_CH-1:0] i_latch_fault,
  input wire logic [NUM_CH-1:0] i_run_pin,
  // Same-clock state
  input wire logic [NUM_CH-1:0] i_op_on,
  input wire logic [NUM_CH-1:0] i_output_on,
  input wire logic [NUM_CH-1:0] i_power_good,
  input wire logic i_busy_fault,
  input wire logic [7:0] i_cml_event,
  input wire logic [NUM_CH-1:0][7:0] i_temp_status,
  input wire logic [7:0] i_input_status,
  input wire logic [NUM_CH-1:0][7:0] i_mfr_status,
  // Strobes and state out
  output logic o_clear_faults,
  output logic o_clear_peaks,
  output logic [NUM_CH-1:0] o_latched_off,
  // Open-drain alert
  output logic o_alert_o,
  output logic o_alert_oe
);

  localparam int SW = NUM_CH * 11;
  localparam logic [PW:0] NUM_CH_W = (PW + 1)'(NUM_CH);
  localparam int CLR_WAIT = CLEAR_MAX_CYC;

  initial
  begin
    if (NUM_CH < 1 || NUM_CH > 8) $error("NUM_CH must be 1 to 8");
    if (PW < $clog2(NUM_CH)) $error("PW too narrow for NUM_CH");
  end

  // Synchronised detector levels
  logic [SW-1:0] sync_q;
  logic [NUM_CH-1:0][6:0] vout_s;
  logic [NUM_CH-1:0][1:0] iout_s;
  logic [NUM_CH-1:0] latf_s;
  logic [NUM_CH-1:0] run_s;

  signal_sync #(.WIDTH(SW)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_run_pin, i_latch_fault, i_iout_fault, i_vout_fault}),
    .o_sync(sync_q)
  );

  assign {run_s, latf_s, iout_s, vout_s} = sync_q;

  // Mask target slot for a command code
  function automatic logic [2:0] mask_slot(input logic [7:0] code);
    unique case (code)
      CMD_OUTPUT_VOLTAGE_STATUS: mask_slot = MI_VOUT;
      CMD_OUTPUT_CURRENT_STATUS: mask_slot = MI_IOUT;
      CMD_STATUS_INPUT: mask_slot = MI_INPUT;
      CMD_STATUS_TEMP: mask_slot = MI_TEMP;
      CMD_STATUS_CML: mask_slot = MI_CML;
      CMD_STATUS_MFR: mask_slot = MI_MFR;
      default: mask_slot = MI_NONE; // R12
    endcase
  endfunction : mask_slot

  // Command decode
  logic send_form;
  logic clr_cmd;
  logic clr_bad_form;
  logic rst_cmd;
  logic peak_cmd;
  logic mask_wr;
  logic mask_rd;
  logic [2:0] slot;
  logic slot_ok;
  logic page_ok;
  logic [PW-1:0] rd_ch;
  logic w1c_wr;

  assign send_form = i_cmd_valid && i_cmd_kind == KIND_SEND_BYTE;
  assign clr_cmd = send_form && i_cmd_code == CMD_CLEAR_FAULTS; // R05
  assign clr_bad_form = i_cmd_valid && i_cmd_kind != KIND_SEND_BYTE
    && i_cmd_code == CMD_CLEAR_FAULTS; // R05
  assign rst_cmd = send_form && (i_cmd_code == RESET_CMD_CODE
    || i_cmd_code == RESTORE_CMD_CODE);
  assign peak_cmd = send_form && i_cmd_code == CMD_CLEAR_PEAKS;
  assign mask_wr = i_cmd_valid && i_cmd_kind == KIND_WRITE_WORD
    && i_cmd_code == CMD_ALERT_MASK; // R10
  assign mask_rd = i_cmd_valid && i_cmd_kind == KIND_PROC_CALL
    && i_cmd_code == CMD_ALERT_MASK; // R11
  assign slot = mask_slot(i_cmd_d0);
  assign slot_ok = slot != MI_NONE;
  assign page_ok = {1'b0, i_page} < NUM_CH_W;
  assign rd_ch = page_ok ? i_page : '0;
  assign w1c_wr = i_cmd_valid && i_cmd_kind == KIND_WRITE_BYTE;

  // Strobes to peak store and externally held status
  assign o_clear_faults = clr_cmd; // R01
  assign o_clear_peaks = peak_cmd || rst_cmd; // R08

  // Status registers
  logic [NUM_CH-1:0][7:0] vout_q;
  logic [NUM_CH-1:0][7:0] iout_q;
  logic [NUM_CH-1:0] busy_q;
  logic [7:0] cml_q;
  logic [NUM_CH-1:0][7:0] vout_set;
  logic [NUM_CH-1:0][7:0] iout_set;
  logic [NUM_CH-1:0][7:0] sbyte;
  logic [NUM_CH-1:0][7:0] sword_hi;
  logic [NUM_CH-1:0] ch_alert;
  logic [NUM_MASK-1:0][7:0] mask_q [NUM_CH];

  // Per-channel copies; the page selects which one a read sees
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    logic wr_here;
    assign wr_here = w1c_wr && page_ok && i_page == PW'(c); // R24
    assign vout_set[c] = {vout_s[c], 1'b0} & VOUT_SUP; // R19
    assign iout_set[c] = {iout_s[c][1], 1'b0, iout_s[c][0], 5'h00}; // R21

    // Clear-faults wins for one cycle; a set then wins over W1C
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        vout_q[c] <= 8'h00;
      end
      else if (clr_cmd)
      begin
        vout_q[c] <= 8'h00; // R01 R04
      end
      else if (wr_here && i_cmd_code == CMD_OUTPUT_VOLTAGE_STATUS)
      begin
        vout_q[c] <= ((vout_q[c] & ~i_cmd_d0) | vout_set[c]) & VOUT_SUP; // R20
      end
      else
      begin
        vout_q[c] <= vout_q[c] | vout_set[c]; // R03
      end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        iout_q[c] <= 8'h00;
      end
      else if (clr_cmd)
      begin
        iout_q[c] <= 8'h00; // R01
      end
      else if (wr_here && i_cmd_code == CMD_OUTPUT_CURRENT_STATUS)
      begin
        iout_q[c] <= ((iout_q[c] & ~i_cmd_d0) | iout_set[c]) & IOUT_SUP; // R21
      end
      else
      begin
        iout_q[c] <= iout_q[c] | iout_set[c]; // R03
      end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        busy_q[c] <= 1'b0;
      end
      else if (clr_cmd)
      begin
        busy_q[c] <= 1'b0; // R01
      end
      else if (i_busy_fault)
      begin
        busy_q[c] <= 1'b1;
      end
    end

    // Summary byte and word; manufacturer and input land in bit 0
    assign sbyte[c] = {busy_q[c], ~i_output_on[c], vout_q[c][VOUT_OV_FAULT],
      iout_q[c][VOUT_OV_FAULT], 1'b0, |i_temp_status[c], |cml_q,
      (|i_mfr_status[c]) | (|i_input_status)}; // R14 R15
    assign sword_hi[c] = {|vout_q[c], |iout_q[c], |i_input_status,
      |i_mfr_status[c], ~i_power_good[c], 3'h0}; // R18 R22

    // Summary bits cannot be masked, so busy always alerts
    assign ch_alert[c] = busy_q[c]
      | (|(vout_q[c] & ~mask_q[c][MI_VOUT]))
      | (|(iout_q[c] & ~mask_q[c][MI_IOUT]))
      | (|(i_temp_status[c] & ~mask_q[c][MI_TEMP]))
      | (|(i_mfr_status[c] & ~mask_q[c][MI_MFR])); // R09 R16

    fault_latch u_latch (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_fault(latf_s[c]),
      .i_enable(run_s[c] && i_op_on[c]),
      .i_restart(rst_cmd), // R06 R07
      .o_latched(o_latched_off[c])
    );
  end

  // Common communication status, not paged
  logic [7:0] cml_set;
  assign cml_set = i_cml_event
    | ({7'h00, clr_bad_form} << CML_BAD_CMD)
    | ({7'h00, (mask_wr || mask_rd) && !slot_ok} << CML_BAD_DATA); // R12

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cml_q <= 8'h00;
    end
    else if (clr_cmd)
    begin
      cml_q <= 8'h00; // R01
    end
    else if (w1c_wr && i_cmd_code == CMD_STATUS_CML)
    begin
      cml_q <= ((cml_q & ~i_cmd_d0) | cml_set) & CML_SUP;
    end
    else
    begin
      cml_q <= (cml_q | cml_set) & CML_SUP;
    end
  end

  // Alert masks; unpaged targets are written to every copy
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        mask_q[c] <= MASK_RST; // R13
      end
    end
    else if (mask_wr && slot_ok && page_ok)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (!MASK_PAGED[slot] || i_page == PW'(c))
        begin
          mask_q[c][slot] <= i_cmd_d1; // R10
        end
      end
    end
  end

  // Alert line
  logic alert_any;
  logic alert_q;
  assign alert_any = (|ch_alert)
    | (|(i_input_status & ~mask_q[0][MI_INPUT]))
    | (|(cml_q & ~mask_q[0][MI_CML])); // R23

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      alert_q <= 1'b0;
    end
    else
    begin
      alert_q <= alert_any && !clr_cmd; // R02 R03
    end
  end

  assign o_alert_o = 1'b0;
  assign o_alert_oe = alert_q; // R23

  // Read answers, one cycle after the request
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rsp_valid <= 1'b0;
    end
    else
    begin
      o_rsp_valid <= (i_cmd_valid && i_cmd_kind == KIND_READ) || mask_rd;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rsp_data <= 16'h0000;
    end
    else if (mask_rd)
    begin
      o_rsp_data <= slot_ok ? {8'h00, mask_q[rd_ch][slot]} : 16'h0000; // R11
    end
    else if (i_cmd_valid && i_cmd_kind == KIND_READ)
    begin
      unique case (i_cmd_code)
        CMD_STATUS_BYTE: o_rsp_data <= {8'h00, sbyte[rd_ch]}; // R14
        CMD_STATUS_WORD: o_rsp_data <= {sword_hi[rd_ch], sbyte[rd_ch]}; // R17
        CMD_OUTPUT_VOLTAGE_STATUS: o_rsp_data <= {8'h00, vout_q[rd_ch]}; // R24
        CMD_OUTPUT_CURRENT_STATUS: o_rsp_data <= {8'h00, iout_q[rd_ch]};
        CMD_STATUS_INPUT: o_rsp_data <= {8'h00, i_input_status};
        CMD_STATUS_TEMP: o_rsp_data <= {8'h00, i_temp_status[rd_ch]};
        CMD_STATUS_CML: o_rsp_data <= {8'h00, cml_q};
        CMD_STATUS_MFR: o_rsp_data <= {8'h00, i_mfr_status[rd_ch]};
        default: o_rsp_data <= 16'h0000;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_clear_wipes_all: assert property ( // R01
    clr_cmd |=> vout_q == '0 && iout_q == '0 && busy_q == '0 && cml_q == 8'h00)
    else $error("clear left a status bit set");

  a_clear_drops_alert: assert property ( // R02
    clr_cmd |=> !o_alert_oe)
    else $error("alert still driven after clear");

  a_fault_returns: assert property ( // R03
    (clr_cmd ##1 (vout_set[0] != 8'h00 && !clr_cmd)) |=> vout_q[0] != 8'h00)
    else $error("persisting fault not set again");

  a_clear_bounded: assert property ( // R04
    clr_cmd |-> ##[1:CLR_WAIT] (vout_q[0] & ~$past(vout_set[0])) == 8'h00)
    else $error("clear not done in time");

  a_masked_recorded: assert property ( // R09
    (vout_set[0] != 8'h00 && !clr_cmd) |=> (vout_q[0] & $past(vout_set[0])) != 8'h00)
    else $error("masked fault not recorded");

  a_alert_has_cause: assert property ( // R23
    o_alert_oe |-> $past(alert_any) && !$past(clr_cmd))
    else $error("alert driven without unmasked cause");

  a_bad_target_flag: assert property ( // R12
    (mask_wr && !slot_ok && !clr_cmd) |=> cml_q[CML_BAD_DATA] ##1 1'b1)
    else $error("bad mask target not flagged");

  a_latch_holds: assert property ( // R06
    (o_latched_off[0] && clr_cmd && !rst_cmd && run_s[0] && i_op_on[0])
      |=> o_latched_off[0])
    else $error("clear restarted a latched channel");

  a_w1c_single: assert property ( // R20
    (w1c_wr && !clr_cmd && i_page == '0 && i_cmd_code == CMD_OUTPUT_VOLTAGE_STATUS
      && i_cmd_d0 == 8'h80 && vout_set[0] == 8'h00)
      |=> !vout_q[0][VOUT_OV_FAULT] && vout_q[0][6:1] == $past(vout_q[0][6:1]))
    else $error("write one did not clear one bit alone");

  a_reset_clears_peaks: assert property ( // R08
    rst_cmd |-> o_clear_peaks)
    else $error("reset command skipped peak clear");

endmodule : pmbus_fault_status_alert

// ==== verilog/pmbus_fault_pkg.sv ====
// Shared constants for the fault status, alert mask and clear bank.
// Assumes commands arrive already framed and decoded by the serial engine.
package pmbus_fault_pkg;

  // Transaction forms delivered by the serial engine
  typedef enum logic [2:0]
  {
    KIND_SEND_BYTE,
    KIND_WRITE_BYTE,
    KIND_WRITE_WORD,
    KIND_READ,
    KIND_PROC_CALL
  } cmd_kind_t;

  // Command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_ALERT_MASK = 8'h1B;
  localparam logic [7:0] CMD_CLEAR_PEAKS = 8'hE3;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS = 8'h7A;
  localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7B;
  localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;
  localparam logic [7:0] CMD_STATUS_TEMP = 8'h7D;
  localparam logic [7:0] CMD_STATUS_CML = 8'h7E;
  localparam logic [7:0] CMD_STATUS_MFR = 8'h80;
  localparam logic [7:0] CMD_PAD_STATE = 8'hE5;
  localparam logic [7:0] CMD_COMMON_STATUS = 8'hEF;

  // Mask slots
  localparam int NUM_MASK = 6;
  localparam logic [2:0] MI_VOUT = 3'h0;
  localparam logic [2:0] MI_IOUT = 3'h1;
  localparam logic [2:0] MI_INPUT = 3'h2;
  localparam logic [2:0] MI_TEMP = 3'h3;
  localparam logic [2:0] MI_CML = 3'h4;
  localparam logic [2:0] MI_MFR = 3'h5;
  localparam logic [2:0] MI_NONE = 3'h7;
  localparam logic [NUM_MASK-1:0] MASK_PAGED = 6'h2B;
  localparam logic [NUM_MASK-1:0][7:0] MASK_RST =
    {8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Supported bits and field positions
  localparam logic [7:0] VOUT_SUP = 8'hFE;
  localparam logic [7:0] IOUT_SUP = 8'hA0;
  localparam logic [7:0] CML_SUP = 8'hFB;
  localparam logic [2:0] CML_BAD_CMD = 3'h7;
  localparam logic [2:0] CML_BAD_DATA = 3'h6;
  localparam logic [2:0] VOUT_OV_FAULT = 3'h7;

  // Clear processing time
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLEAR_MAX_US = 10;
  localparam int CLEAR_MAX_CYC = (CLEAR_MAX_US * 1000) / CLK_PERIOD_NS;

endpackage : pmbus_fault_pkg

// ==== verilog/signal_sync.sv ====
// Three-stage synchroniser for a bundle of asynchronous level inputs.
// Assumes each bit is an independent level; no bus coherency is given.
`timescale 1ns/1ns
module signal_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  initial
  begin
    if (WIDTH < 1) $error("signal_sync width must be positive");
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      o_sync <= '0;
    end
    else
    begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A bit moves only once stages two and three agree
      o_sync <= (s2_q & s3_q) | (o_sync & (s2_q | s3_q));
    end
  end

endmodule : signal_sync

// ==== verilog/fault_latch.sv ====
// Latched-off state of one output channel after a shutdown fault.
// Assumes the fault and enable levels are already in the clock domain.
`timescale 1ns/1ns
module fault_latch (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Causes
  input wire logic i_fault,
  input wire logic i_enable,
  input wire logic i_restart,
  // State
  output logic o_latched
);

  // Commanded off clears the latch, so the next on is a fresh start;
  // a fault still present keeps it set, since set wins
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_latched <= 1'b0; // R07
    end
    else if (i_fault)
    begin
      o_latched <= 1'b1;
    end
    else if (!i_enable || i_restart)
    begin
      o_latched <= 1'b0; // R07
    end
  end

endmodule : fault_latch

// ==== dv/pmbus_host_model.sv ====
// Host side model: issues decoded transactions and resolves the alert line.
// Assumes the bench calls xfer from its own thread; the alert line has a pull-up.
`timescale 1ns/1ns
module pmbus_host_model
  import pmbus_fault_pkg::*;
(
  // Clock and alert
  input wire logic i_clk,
  input wire logic i_alert_o,
  input wire logic i_alert_oe,
  // Command
  output logic o_cmd_valid,
  output cmd_kind_t o_cmd_kind,
  output logic [7:0] o_cmd_code,
  output logic [7:0] o_cmd_d0,
  output logic [7:0] o_cmd_d1,
  // Resolved line
  output logic o_alert_n
);
  // Pull-up wins while the device lets go
  assign o_alert_n = i_alert_oe ? i_alert_o : 1'b1;

  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_kind = KIND_SEND_BYTE;
    o_cmd_code = 8'h00;
    o_cmd_d0 = 8'h00;
    o_cmd_d1 = 8'h00;
  end

  // Send byte carries no data, mask write carries target then mask, call carries the target only
  task automatic xfer(input cmd_kind_t k, input logic [7:0] c, input logic [7:0] a,
                      input logic [7:0] b);
    @(negedge i_clk);
    o_cmd_valid = 1'b1;
    o_cmd_kind = k;
    o_cmd_code = c;
    o_cmd_d0 = a;
    o_cmd_d1 = b;
    @(negedge i_clk);
    // Code and data fields scrambled after release so a stale value is never trusted; the kind is left as it was
    o_cmd_valid = 1'b0;
    o_cmd_code = ~c;
    o_cmd_d0 = ~a;
    o_cmd_d1 = ~b;
  endtask : xfer
endmodule : pmbus_host_model

// ==== dv/pmbus_fault_status_alert_tb.sv ====
// Self-checking bench for the fault status bank with a host model.
// Assumes two channels and detector inputs driven at the falling edge.
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module pmbus_fault_status_alert_tb
  import pmbus_fault_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic cv, rv, alert_o, alert_oe, alert_n, pg;
  cmd_kind_t ck;
  logic [7:0] cc, d0, d1;
  logic [15:0] rd_q;
  logic [1:0][6:0] vf = '0;
  logic [1:0][1:0] iof = '0;
  logic [1:0] lf = '0, run = 2'h3, op = 2'h3, on = '0, good = '0, lat;
  logic [1:0][7:0] mfr = '0, tmp = '0;
  logic busy = 1'b0;
  int error_cnt = 0, comparisons = 0, clr_cnt = 0, pk_cnt = 0;
  logic clr, pk;

  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (clr === 1'b1) clr_cnt++;
  always @(posedge i_clk) if (pk === 1'b1) pk_cnt++;

  pmbus_host_model i_host (.i_clk(i_clk), .i_alert_o(alert_o), .i_alert_oe(alert_oe),
    .o_cmd_valid(cv), .o_cmd_kind(ck), .o_cmd_code(cc), .o_cmd_d0(d0), .o_cmd_d1(d1),
    .o_alert_n(alert_n));

  pmbus_fault_status_alert i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(cv),
    .i_cmd_kind(ck), .i_cmd_code(cc), .i_cmd_d0(d0), .i_cmd_d1(d1), .i_page(pg),
    .o_rsp_valid(rv), .o_rsp_data(rd_q), .i_vout_fault(vf), .i_iout_fault(iof),
    .i_latch_fault(lf), .i_run_pin(run), .i_op_on(op), .i_output_on(on),
    .i_power_good(good), .i_busy_fault(busy), .i_cml_event(8'h00), .i_temp_status(tmp),
    .i_input_status(8'h00), .i_mfr_status(mfr), .o_clear_faults(clr), .o_clear_peaks(pk),
    .o_latched_off(lat), .o_alert_o(alert_o), .o_alert_oe(alert_oe));

  task automatic summarize();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    i_host.xfer(KIND_READ, c, 8'h00, 8'h00);
    `CHK(rv, 1'b1)
    `CHK(rd_q, e)
  endtask : rd

  task automatic mrd(input logic [7:0] t, input logic [15:0] e);
    i_host.xfer(KIND_PROC_CALL, CMD_ALERT_MASK, t, 8'h00);
    `CHK(rv, 1'b1)
    `CHK(rd_q, e)
  endtask : mrd

  task automatic clear();
    i_host.xfer(KIND_SEND_BYTE, CMD_CLEAR_FAULTS, 8'h00, 8'h00);
    cyc(2);
  endtask : clear

  task automatic t_reset();
    logic [7:0] codes [6] = '{8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h80};
    foreach (codes[i]) mrd(codes[i], (i == 5) ? 16'h0011 : 16'h0000);
    rd(CMD_STATUS_BYTE, 16'h0040);
    rd(CMD_STATUS_WORD, 16'h0840);
    on = 2'h3;
    good = 2'h3;
    cyc(2);
    rd(CMD_STATUS_WORD, 16'h0000);
    `CHK(alert_n, 1'b1)
  endtask : t_reset

  task automatic t_vout();
    vf[0][6] = 1'b1;
    cyc(6);
    rd(CMD_OUTPUT_VOLTAGE_STATUS, 16'h0080);
    rd(CMD_STATUS_BYTE, 16'h0020);
    rd(CMD_STATUS_WORD, 16'h8020);
    `CHK(alert_n, 1'b0)
    pg = 1'b1;
    rd(CMD_OUTPUT_VOLTAGE_STATUS, 16'h0000);
    pg = 1'b0;
    i_host.xfer(KIND_WRITE_BYTE, CMD_OUTPUT_VOLTAGE_STATUS, 8'h80, 8'h00);
    cyc(3);
    rd(CMD_OUTPUT_VOLTAGE_STATUS, 16'h0080);
    vf[0][6] = 1'b0;
    vf[0][0] = 1'b1;
    cyc(6);
    vf[0][0] = 1'b0;
    cyc(6);
    i_host.xfer(KIND_WRITE_BYTE, CMD_OUTPUT_VOLTAGE_STATUS, 8'h80, 8'h00);
    cyc(3);
    rd(CMD_OUTPUT_VOLTAGE_STATUS, 16'h0002);
    clear();
  endtask : t_vout

  task automatic t_clear();
    int n;
    iof[0] = 2'b10;
    cyc(6);
    rd(CMD_OUTPUT_CURRENT_STATUS, 16'h0080);
    rd(CMD_STATUS_WORD, 16'h4010);
    iof[0] = 2'b00;
    cyc(6);
    n = clr_cnt;
    clear();
    `CHK(clr_cnt, n + 1)
    rd(CMD_OUTPUT_CURRENT_STATUS, 16'h0000);
    `CHK(alert_n, 1'b1)
    vf[0][5] = 1'b1;
    cyc(6);
    clear();
    cyc(3);
    rd(CMD_OUTPUT_VOLTAGE_STATUS, 16'h0040);
    `CHK(alert_n, 1'b0)
    vf[0][5] = 1'b0;
    cyc(6);
    clear();
    // Busy is unmaskable and lands in bit 7 of every channel
    busy = 1'b1;
    cyc(1);
    busy = 1'b0;
    rd(CMD_STATUS_BYTE, 16'h0080);
    `CHK(alert_n, 1'b0)
    clear();
    rd(CMD_STATUS_BYTE, 16'h0000);
  endtask : t_clear

  task automatic t_refuse();
    logic [7:0] bad [4] = '{8'h78, 8'h79, 8'hE5, 8'hEF};
    int n = clr_cnt;
    i_host.xfer(KIND_WRITE_BYTE, CMD_CLEAR_FAULTS, 8'h00, 8'h00);
    `CHK(clr_cnt, n)
    rd(CMD_STATUS_CML, 16'h0080);
    clear();
    foreach (bad[i])
    begin
      i_host.xfer(KIND_WRITE_WORD, CMD_ALERT_MASK, bad[i], 8'h20);
      rd(CMD_STATUS_CML, 16'h0040);
      mrd(bad[i], 16'h0000);
      clear();
    end
  endtask : t_refuse

  task automatic t_mask();
    i_host.xfer(KIND_WRITE_WORD, CMD_ALERT_MASK, CMD_OUTPUT_CURRENT_STATUS, 8'h20);
    mrd(CMD_OUTPUT_CURRENT_STATUS, 16'h0020);
    iof[0] = 2'b01;
    cyc(6);
    rd(CMD_OUTPUT_CURRENT_STATUS, 16'h0020);
    `CHK(alert_n, 1'b1)
    i_host.xfer(KIND_WRITE_WORD, CMD_ALERT_MASK, CMD_OUTPUT_CURRENT_STATUS, 8'h00);
    cyc(3);
    `CHK(alert_n, 1'b0)
    iof[0] = 2'b00;
    cyc(6);
    clear();
    mfr[0] = 8'h04;
    cyc(2);
    rd(CMD_STATUS_WORD, 16'h1001);
    `CHK(alert_n, 1'b0)
    mfr[0] = 8'h10;
    cyc(3);
    `CHK(alert_n, 1'b1)
    mfr[0] = 8'h00;
    clear();
    tmp[0] = 8'h40;
    cyc(2);
    rd(CMD_STATUS_BYTE, 16'h0004);
    `CHK(alert_n, 1'b0)
    i_host.xfer(KIND_WRITE_WORD, CMD_ALERT_MASK, CMD_STATUS_TEMP, 8'h40);
    cyc(3);
    `CHK(alert_n, 1'b1)
    rd(CMD_STATUS_TEMP, 16'h0040);
    i_host.xfer(KIND_WRITE_WORD, CMD_ALERT_MASK, CMD_STATUS_TEMP, 8'h00);
    tmp[0] = 8'h00;
    clear();
  endtask : t_mask

  task automatic latch_ch0();
    lf[0] = 1'b1;
    cyc(8);
    lf[0] = 1'b0;
    cyc(6);
    `CHK(lat[0], 1'b1)
  endtask : latch_ch0

  task automatic t_latch();
    int n;
    lf[0] = 1'b1;
    cyc(8);
    `CHK(lat[0], 1'b1)
    lf[0] = 1'b0;
    cyc(6);
    clear();
    `CHK(lat[0], 1'b1)
    run[0] = 1'b0;
    cyc(6);
    run[0] = 1'b1;
    cyc(6);
    `CHK(lat[0], 1'b0)
    latch_ch0();
    op[0] = 1'b0;
    cyc(2);
    op[0] = 1'b1;
    cyc(2);
    `CHK(lat[0], 1'b0)
    latch_ch0();
    n = pk_cnt;
    i_host.xfer(KIND_SEND_BYTE, 8'hF0, 8'h00, 8'h00);
    cyc(2);
    `CHK(lat[0], 1'b0)
    `CHK(pk_cnt, n + 1)
    i_host.xfer(KIND_SEND_BYTE, CMD_CLEAR_PEAKS, 8'h00, 8'h00);
    `CHK(pk_cnt, n + 2)
    latch_ch0();
    i_host.xfer(KIND_SEND_BYTE, 8'hF1, 8'h00, 8'h00);
    cyc(2);
    `CHK(lat[0], 1'b0)
    `CHK(pk_cnt, n + 3)
    // Bias cycle: a mid-run reset frees the channel and restores masks
    latch_ch0();
    i_host.xfer(KIND_WRITE_WORD, CMD_ALERT_MASK, CMD_OUTPUT_CURRENT_STATUS, 8'h20);
    i_rst_n = 1'b0;
    cyc(2);
    `CHK(lat[0], 1'b0)
    i_rst_n = 1'b1;
    cyc(2);
    mrd(CMD_OUTPUT_CURRENT_STATUS, 16'h0000);
    clear();
  endtask : t_latch

  initial
  begin
    pg = 1'b0;
    repeat (10) @(negedge i_clk);
    i_rst_n = 1'b1;
    cyc(2);
    t_reset();
    t_vout();
    t_clear();
    t_refuse();
    t_mask();
    t_latch();
    summarize();
  end

  // Hang guard
  initial
  begin
    #500000;
    error_cnt++;
    summarize();
  end
endmodule : pmbus_fault_status_alert_tb
